// ### dmpps_pkg.sv
// Purpose: shared constants for the digital microphone port and shared-pin selection
// Assumes: 32-bit register port with byte offsets; link clock is the 24 MHz internal clock
// Notes:   register layout, field positions, reset values and clock generation figures
package dmpps_pkg;

  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] DMPPS_OFF_CTRL   = 8'h00;
  localparam logic [7:0] DMPPS_OFF_MODE   = 8'h04;
  localparam logic [7:0] DMPPS_OFF_GPIO   = 8'h08;
  localparam logic [7:0] DMPPS_OFF_STATUS = 8'h0C;

  // control register fields
  localparam int DMPPS_CTRL_PS_LSB     = 0;  // power state, 2 bits
  localparam int DMPPS_CTRL_MIC0_EN    = 2;  // microphone input widget 0 enable
  localparam int DMPPS_CTRL_MIC1_EN    = 3;  // microphone input widget 1 enable
  localparam int DMPPS_CTRL_GPIO_SHR   = 4;  // gpio on shared mic/volume pins
  localparam int DMPPS_CTRL_GPIO_BIAS  = 5;  // gpio on bias-reference pins
  localparam int DMPPS_CTRL_CLKSEL_LSB = 6;  // mic clock select, 2 bits
  localparam int DMPPS_CTRL_WIDTH      = 8;

  // mode register fields: one 2-bit capture mode per data pin
  localparam int DMPPS_MODE_PIN0_LSB = 0;
  localparam int DMPPS_MODE_PIN1_LSB = 2;
  localparam int DMPPS_MODE_WIDTH    = 4;

  // gpio register fields
  localparam int DMPPS_GPIO_SHR_DO_LSB  = 0;
  localparam int DMPPS_GPIO_SHR_DIR_LSB = 2;
  localparam int DMPPS_GPIO_BIA_DO_LSB  = 4;
  localparam int DMPPS_GPIO_BIA_DIR_LSB = 6;
  localparam int DMPPS_GPIO_WIDTH       = 8;

  // status register fields
  localparam int DMPPS_ST_RUN      = 0;
  localparam int DMPPS_ST_DRIVE    = 1;
  localparam int DMPPS_ST_FUNC_LSB = 2;
  localparam int DMPPS_ST_SHR_LSB  = 4;
  localparam int DMPPS_ST_BIA_LSB  = 6;
  localparam int DMPPS_ST_WORD_LSB = 8;

  // power states
  localparam logic [1:0] DMPPS_PS_D0 = 2'h0;
  localparam logic [1:0] DMPPS_PS_D3 = 2'h3;

  // capture modes per data pin
  localparam logic [1:0] DMPPS_MODE_SINGLE_RISE = 2'h0;  // one mic, both channels in phase
  localparam logic [1:0] DMPPS_MODE_SINGLE_FALL = 2'h1;  // one mic on falling slot, in phase
  localparam logic [1:0] DMPPS_MODE_SINGLE_HALF = 2'h2;  // one mic, right half a period late
  localparam logic [1:0] DMPPS_MODE_DOUBLE      = 2'h3;  // two mics: rise left, fall right

  // shared-pin functions
  localparam logic [1:0] DMPPS_FN_GPIO   = 2'h0;
  localparam logic [1:0] DMPPS_FN_VOLUME = 2'h1;
  localparam logic [1:0] DMPPS_FN_MIC    = 2'h2;

  // reset values
  localparam logic [1:0] DMPPS_CLKSEL_RST = 2'h1;  // 2.352 MHz
  localparam logic [DMPPS_CTRL_WIDTH-1:0] DMPPS_CTRL_RST =
    {DMPPS_CLKSEL_RST, 4'h0, DMPPS_PS_D3};
  localparam logic [DMPPS_MODE_WIDTH-1:0] DMPPS_MODE_RST = 4'h0;
  localparam logic [DMPPS_GPIO_WIDTH-1:0] DMPPS_GPIO_RST = 8'h00;

  // mic clock generation: step frequency and link clock in kHz
  localparam int DMPPS_LINK_CLK_KHZ = 24000;
  localparam int DMPPS_MIC_STEP_KHZ = 1176;
  localparam logic [15:0] DMPPS_ACC_MOD  = 16'(DMPPS_LINK_CLK_KHZ);
  localparam logic [15:0] DMPPS_INC_UNIT = 16'(2 * DMPPS_MIC_STEP_KHZ);

endpackage

// ### dmpps_top.sv
// Purpose: digital microphone capture port with clock gating and shared-pin selection
// Assumes: link_clk_in is the 24 MHz internal clock; bus on clk_in; async active-low reset
// Notes:   mic clock made by a phase accumulator on link_clk_in; words cross by toggle
`timescale 1ns/1ps
module dmpps_top
  import dmpps_pkg::*;
#(
  parameter bit MIC_SUPPORT = 1'b1
)
(
  // clocks and reset
  input  wire logic        clk_in,
  input  wire logic        link_clk_in,
  input  wire logic        arst_n_in,
  // register port
  input  wire logic [7:0]  bus_addr_in,
  input  wire logic [31:0] bus_wdata_in,
  input  wire logic        bus_wr_in,
  input  wire logic        bus_rd_in,
  output logic      [31:0] bus_rdata_out,
  // microphone clock pin
  output logic             mic_bitclock_out,
  output logic             mic_bitclock_oe_out,
  output logic             mic_bitclock_pd_out,
  // shared data / volume / gpio pins
  input  wire logic        mic_bitstream_in0,
  input  wire logic        mic_bitstream_in1,
  output logic      [1:0]  shr_pin_do_out,
  output logic      [1:0]  shr_pin_oe_out,
  output logic      [1:0]  shr_pin_pu_out,
  output logic      [1:0]  shr_pin_pd_out,
  output logic      [1:0]  shr_func_out,
  // bias-reference / gpio pins
  input  wire logic [1:0]  bias_pin_in,
  output logic      [1:0]  bias_pin_do_out,
  output logic      [1:0]  bias_pin_oe_out,
  output logic             bias_ref_out_e_out,
  output logic             bias_ref_out_f_out,
  // ADC paths
  output logic             adc0_left_out,
  output logic             adc0_right_out,
  output logic             adc0_valid_out,
  output logic             adc1_left_out,
  output logic             adc1_right_out,
  output logic             adc1_valid_out
);

  // core-domain registers
  logic [DMPPS_CTRL_WIDTH-1:0] ctrl_r;
  logic [DMPPS_MODE_WIDTH-1:0] mode_r;
  logic [DMPPS_GPIO_WIDTH-1:0] gpio_r;
  logic                        run_r;
  logic                        drive_r;
  logic [1:0]                  pin_en_r;
  logic [1:0]                  shr_q1_r;
  logic [1:0]                  shr_s_r;
  logic [1:0]                  bia_q1_r;
  logic [1:0]                  bia_s_r;
  logic                        xt_q1_r;
  logic                        xt_s_r;
  logic                        xt_d_r;
  logic [3:0]                  word_r;
  logic [31:0]                 rdata_r;

  // link-domain registers
  logic                        lrst_q1_r;
  logic                        lrst_n_r;
  logic [5:0]                  lctl_q1_r;
  logic [5:0]                  lctl_s_r;
  logic [1:0]                  lpin_q1_r;
  logic [1:0]                  lpin_s_r;
  logic [15:0]                 acc_r;
  logic                        mclk_r;
  logic                        mclk_oe_r;
  logic                        mclk_pd_r;
  logic [1:0]                  rise_smp_r;
  logic [3:0]                  xword_r;
  logic                        xtog_r;

  // register decode
  wire logic        wr_ctrl_w = bus_wr_in && (bus_addr_in == DMPPS_OFF_CTRL);
  wire logic        wr_mode_w = bus_wr_in && (bus_addr_in == DMPPS_OFF_MODE);
  wire logic        wr_gpio_w = bus_wr_in && (bus_addr_in == DMPPS_OFF_GPIO);

  // control fields
  wire logic [1:0]  pstate_w   = ctrl_r[DMPPS_CTRL_PS_LSB +: 2];
  wire logic        mic0_en_w  = ctrl_r[DMPPS_CTRL_MIC0_EN];
  wire logic        mic1_en_w  = ctrl_r[DMPPS_CTRL_MIC1_EN];
  wire logic        gpio_shr_w = ctrl_r[DMPPS_CTRL_GPIO_SHR];
  wire logic        gpio_bia_w = ctrl_r[DMPPS_CTRL_GPIO_BIAS];
  wire logic [1:0]  clksel_w   = ctrl_r[DMPPS_CTRL_CLKSEL_LSB +: 2];
  wire logic [1:0]  mode0_w    = mode_r[DMPPS_MODE_PIN0_LSB +: 2];
  wire logic [1:0]  mode1_w    = mode_r[DMPPS_MODE_PIN1_LSB +: 2];

  // shared-pin precedence: gpio, then microphone, then volume at reset
  wire logic        mic_req_w   = MIC_SUPPORT && (mic0_en_w || mic1_en_w);
  wire logic        mic_fn_w    = !gpio_shr_w && mic_req_w;
  wire logic [1:0]  func_nxt    = gpio_shr_w ? DMPPS_FN_GPIO :
                                  mic_fn_w   ? DMPPS_FN_MIC :
                                               DMPPS_FN_VOLUME;
  wire logic        vol_fn_w    = (func_nxt == DMPPS_FN_VOLUME);

  // clock gating by widget enable and power state
  wire logic        drive_nxt   = mic_fn_w;
  wire logic        run_nxt     = mic_fn_w && (pstate_w == DMPPS_PS_D0);
  wire logic [1:0]  pin_en_nxt  = {run_nxt && mic1_en_w, run_nxt && mic0_en_w};

  // word arrival from link domain
  wire logic        xfer_w      = xt_s_r ^ xt_d_r;

  // channel assignment per pin from rising and falling samples
  function automatic logic [1:0] dmpps_chan(input logic [1:0] mode,
                                            input logic       rs,
                                            input logic       fs);
    logic [1:0] lr;
    lr = {rs, fs};
    case (mode)
      DMPPS_MODE_SINGLE_RISE: lr = {rs, rs};
      DMPPS_MODE_SINGLE_FALL: lr = {fs, fs};
      DMPPS_MODE_SINGLE_HALF: lr = {rs, fs};
      DMPPS_MODE_DOUBLE:      lr = {rs, fs};
      default:                lr = {rs, fs};
    endcase
    return lr;
  endfunction

  // each pin feeds its own ADC path, so two pins use two paths
  wire logic [1:0]  adc0_lr_w = dmpps_chan(mode0_w, word_r[0], word_r[1]);
  wire logic [1:0]  adc1_lr_w = dmpps_chan(mode1_w, word_r[2], word_r[3]);

  // read mux
  wire logic [31:0] status_w = {20'h0,
                                word_r,
                                bia_s_r,
                                shr_s_r,
                                func_nxt,
                                drive_r,
                                run_r};
  wire logic [31:0] rsel_w   = (bus_addr_in == DMPPS_OFF_CTRL)   ? {24'h0, ctrl_r} :
                               (bus_addr_in == DMPPS_OFF_MODE)   ? {28'h0, mode_r} :
                               (bus_addr_in == DMPPS_OFF_GPIO)   ? {24'h0, gpio_r} :
                               (bus_addr_in == DMPPS_OFF_STATUS) ? status_w :
                                                                   32'h0;
  wire logic [31:0] rdata_nxt = bus_rd_in ? rsel_w : 32'h0;

  // pin control next values
  wire logic [1:0]  shr_oe_nxt = gpio_shr_w ? gpio_r[DMPPS_GPIO_SHR_DIR_LSB +: 2] : 2'h0;
  wire logic [1:0]  bia_oe_nxt = gpio_bia_w ? gpio_r[DMPPS_GPIO_BIA_DIR_LSB +: 2] : 2'h0;

  // software registers
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctrl_r <= DMPPS_CTRL_RST;
      mode_r <= DMPPS_MODE_RST;
      gpio_r <= DMPPS_GPIO_RST;
    end
    else
    begin
      if (wr_ctrl_w)
        ctrl_r <= bus_wdata_in[DMPPS_CTRL_WIDTH-1:0];
      if (wr_mode_w)
        mode_r <= bus_wdata_in[DMPPS_MODE_WIDTH-1:0];
      if (wr_gpio_w)
        gpio_r <= bus_wdata_in[DMPPS_GPIO_WIDTH-1:0];
    end
  end

  // gating state and read data
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      run_r    <= 1'b0;
      drive_r  <= 1'b0;
      pin_en_r <= 2'h0;
      rdata_r  <= 32'h0;
    end
    else
    begin
      run_r    <= run_nxt;
      drive_r  <= drive_nxt;
      pin_en_r <= pin_en_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // pin input synchronisers, core side
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      shr_q1_r <= 2'h0;
      shr_s_r  <= 2'h0;
      bia_q1_r <= 2'h0;
      bia_s_r  <= 2'h0;
    end
    else
    begin
      shr_q1_r <= {mic_bitstream_in1, mic_bitstream_in0};
      shr_s_r  <= shr_q1_r;
      bia_q1_r <= bias_pin_in;
      bia_s_r  <= bia_q1_r;
    end
  end

  // word toggle synchroniser; the word is held steady for several link cycles
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      xt_q1_r <= 1'b0;
      xt_s_r  <= 1'b0;
      xt_d_r  <= 1'b0;
      word_r  <= 4'h0;
    end
    else
    begin
      xt_q1_r <= xtog_r;
      xt_s_r  <= xt_q1_r;
      xt_d_r  <= xt_s_r;
      if (xfer_w)
        word_r <= xword_r;
    end
  end

  // ADC path outputs
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      adc0_left_out  <= 1'b0;
      adc0_right_out <= 1'b0;
      adc0_valid_out <= 1'b0;
      adc1_left_out  <= 1'b0;
      adc1_right_out <= 1'b0;
      adc1_valid_out <= 1'b0;
    end
    else
    begin
      adc0_left_out  <= adc0_lr_w[1];
      adc0_right_out <= adc0_lr_w[0];
      adc0_valid_out <= xfer_w && pin_en_r[0];
      adc1_left_out  <= adc1_lr_w[1];
      adc1_right_out <= adc1_lr_w[0];
      adc1_valid_out <= xfer_w && pin_en_r[1];
    end
  end

  // shared and bias pin function outputs
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      shr_func_out       <= DMPPS_FN_VOLUME;
      shr_pin_pu_out     <= 2'h3;
      shr_pin_pd_out     <= 2'h0;
      shr_pin_do_out     <= 2'h0;
      shr_pin_oe_out     <= 2'h0;
      bias_pin_do_out    <= 2'h0;
      bias_pin_oe_out    <= 2'h0;
      bias_ref_out_e_out <= 1'b1;
      bias_ref_out_f_out <= 1'b1;
    end
    else
    begin
      shr_func_out       <= func_nxt;
      shr_pin_pu_out     <= {2{vol_fn_w}};
      shr_pin_pd_out     <= {2{mic_fn_w}};
      shr_pin_do_out     <= gpio_r[DMPPS_GPIO_SHR_DO_LSB +: 2];
      shr_pin_oe_out     <= shr_oe_nxt;
      bias_pin_do_out    <= gpio_r[DMPPS_GPIO_BIA_DO_LSB +: 2];
      bias_pin_oe_out    <= bia_oe_nxt;
      bias_ref_out_e_out <= !gpio_bia_w;
      bias_ref_out_f_out <= !gpio_bia_w;
    end
  end

  // link domain

  wire logic [1:0]  l_clksel_w = lctl_s_r[5:4];
  wire logic [1:0]  l_pin_en_w = lctl_s_r[3:2];
  wire logic        l_run_w    = lctl_s_r[1];
  wire logic        l_drive_w  = lctl_s_r[0];

  // accumulator step is twice the mic clock in kHz, so it toggles at 2*f
  wire logic [15:0] inc_w  = DMPPS_INC_UNIT * {14'h0, l_clksel_w} + DMPPS_INC_UNIT;
  wire logic [15:0] sum_w  = acc_r + inc_w;
  wire logic        wrap_w = (sum_w >= DMPPS_ACC_MOD);
  wire logic        rise_ev_w = l_run_w && wrap_w && !mclk_r;
  wire logic        fall_ev_w = l_run_w && wrap_w && mclk_r;
  wire logic [1:0]  smp_w  = lpin_s_r & l_pin_en_w;

  // reset release synchroniser for the link domain
  always_ff @(posedge link_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      lrst_q1_r <= 1'b0;
      lrst_n_r  <= 1'b0;
    end
    else
    begin
      lrst_q1_r <= 1'b1;
      lrst_n_r  <= lrst_q1_r;
    end
  end

  // control and data pin synchronisers, link side
  always_ff @(posedge link_clk_in or negedge lrst_n_r)
  begin
    if (!lrst_n_r)
    begin
      lctl_q1_r <= 6'h0;
      lctl_s_r  <= 6'h0;
      lpin_q1_r <= 2'h0;
      lpin_s_r  <= 2'h0;
    end
    else
    begin
      lctl_q1_r <= {clksel_w, pin_en_r, run_r, drive_r};
      lctl_s_r  <= lctl_q1_r;
      lpin_q1_r <= {mic_bitstream_in1, mic_bitstream_in0};
      lpin_s_r  <= lpin_q1_r;
    end
  end

  // mic clock generation and pin drive
  always_ff @(posedge link_clk_in or negedge lrst_n_r)
  begin
    if (!lrst_n_r)
    begin
      acc_r     <= 16'h0000;
      mclk_r    <= 1'b0;
      mclk_oe_r <= 1'b0;
      mclk_pd_r <= 1'b1;
    end
    else
    begin
      mclk_oe_r <= l_drive_w;
      mclk_pd_r <= !l_drive_w;
      if (!l_run_w)
      begin
        acc_r  <= 16'h0000;
        mclk_r <= 1'b0;
      end
      else
      begin
        acc_r  <= wrap_w ? (sum_w - DMPPS_ACC_MOD) : sum_w;
        mclk_r <= mclk_r ^ wrap_w;
      end
    end
  end

  // edge-slot capture; a word leaves after each falling slot
  always_ff @(posedge link_clk_in or negedge lrst_n_r)
  begin
    if (!lrst_n_r)
    begin
      rise_smp_r <= 2'h0;
      xword_r    <= 4'h0;
      xtog_r     <= 1'b0;
    end
    else
    begin
      if (rise_ev_w)
        rise_smp_r <= smp_w;
      if (fall_ev_w)
      begin
        xword_r <= {smp_w[1], rise_smp_r[1], smp_w[0], rise_smp_r[0]};
        xtog_r  <= !xtog_r;
      end
    end
  end

  assign mic_bitclock_out    = mclk_r;
  assign mic_bitclock_oe_out = mclk_oe_r;
  assign mic_bitclock_pd_out = mclk_pd_r;
  assign bus_rdata_out       = rdata_r;

endmodule

// ### dmpps_top_monitor.sv
// Purpose: port-level checks for the mic port and shared-pin selection
// Assumes: bound to dmpps_top; both clock domains are reset by arst_n_in
// Notes:   mic clock checks run on link_clk_in, the rest on clk_in
`timescale 1ns/1ps
module dmpps_top_monitor
  import dmpps_pkg::*;
(
  // clocks and reset
  input wire logic        clk_in,
  input wire logic        link_clk_in,
  input wire logic        arst_n_in,
  // register port
  input wire logic        bus_rd_in,
  input wire logic [31:0] bus_rdata_out,
  // mic clock pin
  input wire logic        mic_bitclock_out,
  input wire logic        mic_bitclock_oe_out,
  input wire logic        mic_bitclock_pd_out,
  // shared and bias pins
  input wire logic [1:0]  shr_pin_oe_out,
  input wire logic [1:0]  shr_pin_pu_out,
  input wire logic [1:0]  shr_pin_pd_out,
  input wire logic [1:0]  shr_func_out,
  input wire logic [1:0]  bias_pin_oe_out,
  input wire logic        bias_ref_out_e_out,
  input wire logic        bias_ref_out_f_out,
  // capture path
  input wire logic        adc0_valid_out
);
  sequence s_clk_rise;
    $rose(mic_bitclock_out);
  endsequence
  // slowest setting gives a high phase of 10 or 11 link cycles
  sequence s_clk_fall_soon;
    ##[1:11] !mic_bitclock_out;
  endsequence

  a_clk_phase_max: assert property (
    @(posedge link_clk_in) disable iff (!arst_n_in) s_clk_rise |-> s_clk_fall_soon)
    else $error("mic clock high phase too long");
  a_clk_tristate_low: assert property (
    @(posedge link_clk_in) disable iff (!arst_n_in)
    !mic_bitclock_oe_out |-> !mic_bitclock_out && mic_bitclock_pd_out)
    else $error("released mic clock not low with pull-down");
  a_pd_off_driven: assert property (
    @(posedge link_clk_in) disable iff (!arst_n_in) mic_bitclock_oe_out |-> !mic_bitclock_pd_out)
    else $error("pull-down left on while mic clock driven");
  a_vol_pullups: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    shr_func_out == DMPPS_FN_VOLUME |-> shr_pin_pu_out == 2'h3 && shr_pin_pd_out == 2'h0)
    else $error("volume function without pull-ups");
  a_mic_pulldowns: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    shr_func_out == DMPPS_FN_MIC |-> shr_pin_pu_out == 2'h0 && shr_pin_pd_out == 2'h3)
    else $error("mic function without pull-downs");
  a_gpio_owns_pins: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    shr_pin_oe_out != 2'h0 |-> shr_func_out == DMPPS_FN_GPIO)
    else $error("shared pin driven outside gpio function");
  a_bias_gpio_excl: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    bias_pin_oe_out != 2'h0 |-> !bias_ref_out_e_out && !bias_ref_out_f_out)
    else $error("bias output active beside gpio drive");
  a_valid_one_cycle: assert property (
    @(posedge clk_in) disable iff (!arst_n_in) adc0_valid_out |=> !adc0_valid_out)
    else $error("capture valid longer than one cycle");
  a_rdata_idle_zero: assert property (
    @(posedge clk_in) disable iff (!arst_n_in) !bus_rd_in |=> bus_rdata_out == 32'h0)
    else $error("read data outside read cycle");
endmodule

// ### dmpps_mic_model.sv
// Purpose: behavioural microphones, a left and a right talker on each data pin
// Assumes: the device samples the left slot at the rising clock edge
// Notes:   with the clock pin released the line follows the weak pull
`timescale 1ns/1ps
module dmpps_mic_model
(
  // from the device
  input  wire logic       mic_clk_in,
  input  wire logic       clk_oe_in,
  input  wire logic [1:0] pull_up_in,
  // talker bits per pin
  input  wire logic [1:0] lbit_in,
  input  wire logic [1:0] rbit_in,
  // data pins
  output logic      [1:0] data_out
);
  logic [1:0] drv_r;

  initial drv_r = 2'h0;
  // left talker fills the slot before the rise, right talker the one before the fall
  always @(negedge mic_clk_in) drv_r <= #4 lbit_in;
  always @(posedge mic_clk_in) drv_r <= #4 rbit_in;
  assign data_out = clk_oe_in ? drv_r : pull_up_in;
endmodule

// ### dmpps_top_tb.sv
// Purpose: self-checking bench for the mic port and shared-pin selection
// Assumes: fixed talker bits; pin0 left 1 right 0, pin1 left 0 right 1
// Notes:   link clock 32 ns, each of its edges 1 ns before a rising edge of the 8 ns bus clock
`timescale 1ns/1ps
module dmpps_top_tb
  import dmpps_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        link_clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [7:0]  bus_addr_in = 8'h00;
  logic [31:0] bus_wdata_in = 32'h0;
  logic        bus_wr_in = 1'b0;
  logic        bus_rd_in = 1'b0;
  logic [31:0] bus_rdata_out, rd_v;
  logic        mic_bitclock_out, mic_bitclock_oe_out, mic_bitclock_pd_out;
  logic [1:0]  shr_pin_do_out, shr_pin_oe_out, shr_pin_pu_out, shr_pin_pd_out, shr_func_out;
  logic [1:0]  bias_pin_do_out, bias_pin_oe_out, data_w;
  logic        bias_ref_out_e_out, bias_ref_out_f_out;
  logic        adc0_left_out, adc0_right_out, adc0_valid_out;
  logic        adc1_left_out, adc1_right_out, adc1_valid_out;
  logic [1:0]  lbit = 2'h1;
  logic [1:0]  rbit = 2'h2;
  wire  [1:0]  pin_w = (shr_pin_oe_out & shr_pin_do_out) | (~shr_pin_oe_out & data_w);
  int          fail_count = 0;
  int          checks_done = 0;

  initial forever #4 clk_in = ~clk_in;
  initial
  begin
    #3;
    forever #16 link_clk_in = ~link_clk_in;
  end

  dmpps_top i_dmpps_top (.*, .mic_bitstream_in0(pin_w[0]), .mic_bitstream_in1(pin_w[1]),
                         .bias_pin_in(bias_pin_oe_out & bias_pin_do_out));
  dmpps_mic_model i_dmpps_mic_model (.mic_clk_in(mic_bitclock_out),
    .clk_oe_in(mic_bitclock_oe_out),
    .pull_up_in(shr_pin_pu_out), .lbit_in(lbit), .rbit_in(rbit), .data_out(data_w));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    bus_addr_in <= a;
    bus_wdata_in <= d;
    bus_wr_in <= 1'b1;
    @(posedge clk_in);
    bus_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    bus_addr_in <= a;
    bus_rd_in <= 1'b1;
    @(posedge clk_in);
    bus_rd_in <= 1'b0;
    #1;
    d = bus_rdata_out;
  endtask

  function automatic logic [1:0] exp_lr(input logic [1:0] md, input logic l, input logic r);
    return (md == DMPPS_MODE_SINGLE_RISE) ? {l, l} :
           (md == DMPPS_MODE_SINGLE_FALL) ? {r, r} : {l, r};
  endfunction

  task automatic t_reset;
    rd(DMPPS_OFF_CTRL, rd_v);
    check(rd_v, 32'(DMPPS_CTRL_RST));
    rd(8'h10, rd_v);
    check(rd_v, 32'h0);
    check({shr_func_out, shr_pin_pu_out, shr_pin_pd_out}, {DMPPS_FN_VOLUME, 4'hC});
    check({bias_ref_out_e_out, bias_ref_out_f_out}, 2'h3);
    check({mic_bitclock_oe_out, mic_bitclock_pd_out}, 2'h1);
    $display("test reset done");
  endtask

  task automatic t_gating;
    logic hi;
    int   n;
    wr(DMPPS_OFF_CTRL, 32'h40);
    cyc(30);
    check({mic_bitclock_oe_out, mic_bitclock_pd_out, mic_bitclock_out}, 3'h2);
    for (int p = 1; p < 4; p++)
    begin
      wr(DMPPS_OFF_CTRL, 32'h44 | p);
      cyc(30);
      hi = 1'b0;
      repeat (120)
      begin
        @(negedge clk_in);
        hi = hi | mic_bitclock_out | adc0_valid_out;
      end
      check({mic_bitclock_oe_out, mic_bitclock_pd_out, hi}, 3'h4);
    end
    check({shr_func_out, shr_pin_pu_out, shr_pin_pd_out}, {DMPPS_FN_MIC, 4'h3});
    wr(DMPPS_OFF_CTRL, 32'h44);
    n = 0;
    while (mic_bitclock_out !== 1'b1 && n < 300)
    begin
      @(negedge clk_in);
      n++;
    end
    check(n < 300, 1'b1);
    $display("test gating done");
  endtask

  task automatic t_modes;
    logic [3:0] mt [5] = '{4'h0, 4'h5, 4'hA, 4'hF, 4'h3};
    int         n;
    wr(DMPPS_OFF_CTRL, 32'h4C);
    for (int i = 0; i < 5; i++)
    begin
      wr(DMPPS_OFF_MODE, {28'h0, mt[i]});
      n = 0;
      repeat (3)
      begin
        @(negedge clk_in);
        while (adc0_valid_out !== 1'b1 && n < 3000)
        begin
          @(negedge clk_in);
          n++;
        end
      end
      check(n < 3000, 1'b1);
      check(adc1_valid_out, 1'b1);
      check({adc0_left_out, adc0_right_out, adc1_left_out, adc1_right_out},
            {exp_lr(mt[i][1:0], lbit[0], rbit[0]), exp_lr(mt[i][3:2], lbit[1], rbit[1])});
    end
    $display("test modes done");
  endtask

  task automatic t_freq;
    int   k;
    int   n;
    int   e;
    logic p;
    for (int s = 0; s < 4; s++)
    begin
      wr(DMPPS_OFF_CTRL, {24'h0, s[1:0], 6'h0C});
      e = 96000 / (1176 * (s + 1));
      k = 0;
      n = 0;
      p = 1'b1;
      for (int j = 0; j < 600 && k < 6; j++)
      begin
        @(negedge link_clk_in);
        if (mic_bitclock_out && !p)
          k++;
        if (k >= 2 && k < 6)
          n++;
        p = mic_bitclock_out;
      end
      check(n >= e - 1 && n <= e + 2, 1'b1);
    end
    $display("test frequency done");
  endtask

  task automatic t_gpio;
    wr(DMPPS_OFF_GPIO, 32'hED);
    wr(DMPPS_OFF_CTRL, 32'h7C);
    cyc(30);
    check({shr_func_out, shr_pin_oe_out, shr_pin_do_out}, {DMPPS_FN_GPIO, 4'hD});
    check(mic_bitclock_oe_out, 1'b0);
    check({bias_pin_oe_out, bias_pin_do_out, bias_ref_out_e_out, bias_ref_out_f_out},
          6'h38);
    rd(DMPPS_OFF_GPIO, rd_v);
    check(rd_v, 32'hED);
    rd(DMPPS_OFF_STATUS, rd_v);
    check(rd_v[7:0], 8'h90);
    wr(DMPPS_OFF_CTRL, 32'h40);
    cyc(30);
    check({shr_func_out, shr_pin_oe_out, bias_ref_out_e_out}, {DMPPS_FN_VOLUME, 3'h1});
    $display("test gpio done");
  endtask

  task automatic results;
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (14) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_gating();
    t_modes();
    t_freq();
    t_gpio();
    results();
  end

  initial
  begin
    #400000;
    fail_count++;
    results();
  end
endmodule

bind dmpps_top dmpps_top_monitor i_dmpps_top_monitor (.*);
